// *** dv/spi_link_monitor.sv ***
// Concurrent checks on the link between the flash front end and its master
`timescale 1ns/100ps
`default_nettype none
module spi_link_monitor (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso_o,
    input wire logic miso_oe,
    input wire logic hold_n,
    input wire logic wp_n
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);

    sequence frame_open;
        $fell(cs_n);
    endsequence
    sequence clock_quiet;
        $stable(sck) [*8];
    endsequence
    sequence frame_close;
        $rose(cs_n);
    endsequence
    sequence output_off;
        ##[1:8] !miso_oe;
    endsequence

    deselect_float_a: assert property (cs_n [*8] |-> !miso_oe)
        else $error("serial output driven while deselected");
    release_float_a: assert property (frame_close |-> output_off)
        else $error("serial output still driven after select rose");
    fall_change_a: assert property (miso_oe && $past(miso_oe) && $changed(miso_o) |-> !sck)
        else $error("serial output changed while link clock high");
    mosi_settled_a: assert property (!cs_n && $rose(sck) |-> $stable(mosi) [*4])
        else $error("serial input moved around a rising link clock");
    phase_length_a: assert property (!cs_n && $changed(sck) |=> $stable(sck) [*8])
        else $error("link clock phase too short");
    select_setup_a: assert property (frame_open |=> clock_quiet)
        else $error("link clock moved right after select fell");
    pause_selected_a: assert property ($fell(hold_n) |-> !cs_n)
        else $error("pause requested while deselected");
    pause_clock_low_a: assert property (!hold_n |-> !sck && $stable(sck))
        else $error("link clock not low and still during pause");
    pause_float_a: assert property ((!hold_n) [*8] |-> !miso_oe)
        else $error("serial output driven during pause");
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// Self-checking bench: flash master and front end face each other, plus a hand-driven front end
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic       clock;
    logic       rst_n;
    logic       cmd_valid, cmd_last, cmd_ready, mode3, pause, protect_n;
    logic [7:0] cmd_byte, host_byte, dev_byte, page_offset, tx_byte, status, b_byte, last_off;
    logic       host_valid, host_active, dev_valid, dev_first, tx_taken, frame_end, rejected;
    logic       b_valid, b_first, valid_d;
    logic [8:0] dev_q[$], b_q[$];
    logic [7:0] host_q[$], fr[$];
    int         n_fail, num_checks, rejects, tx_idx, cycles;

    spi_flash_if link ();
    spi_flash_if link_b ();

    flash_master i_flash_master (.CLOCK(clock), .RST_N(rst_n), .LINK(link), .CMD_VALID(cmd_valid),
        .CMD_BYTE(cmd_byte), .CMD_LAST(cmd_last), .CMD_READY(cmd_ready), .MODE3(mode3), .PAUSE(pause),
        .PROTECT_N(protect_n), .RX_BYTE(host_byte), .RX_VALID(host_valid), .ACTIVE(host_active));
    flash_frontend i_flash_frontend (.CLOCK(clock), .RST_N(rst_n), .LINK(link), .RX_BYTE(dev_byte),
        .RX_VALID(dev_valid), .RX_FIRST(dev_first), .PAGE_OFFSET(page_offset), .TX_BYTE(tx_byte),
        .TX_TAKEN(tx_taken), .FRAME_END(frame_end), .STATUS(status), .WRITE_REJECTED(rejected));
    // Second front end is driven by hand so the bench can break the master's rules on purpose
    flash_frontend i_flash_frontend_b (.CLOCK(clock), .RST_N(rst_n), .LINK(link_b), .RX_BYTE(b_byte),
        .RX_VALID(b_valid), .RX_FIRST(b_first), .PAGE_OFFSET(), .TX_BYTE(8'h00), .TX_TAKEN(),
        .FRAME_END(), .STATUS(), .WRITE_REJECTED());
    spi_link_monitor i_spi_link_monitor (.CLOCK(clock), .RST_N(rst_n), .cs_n(link.cs_n), .sck(link.sck),
        .mosi(link.mosi), .miso_o(link.miso_o), .miso_oe(link.miso_oe), .hold_n(link.hold_n),
        .wp_n(link.wp_n));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    function automatic logic [7:0] pat(input int k);
        return 8'hC3 ^ 8'(k);
    endfunction

    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    always @(posedge clock) begin
        cycles++;
        valid_d <= dev_valid;
        if (valid_d === 1'b1) last_off = page_offset;
        if (dev_valid === 1'b1) dev_q.push_back({dev_first, dev_byte});
        if (host_valid === 1'b1) host_q.push_back(host_byte);
        if (b_valid === 1'b1) b_q.push_back({b_first, b_byte});
        if (rejected === 1'b1) rejects++;
        if (cycles == 90000) begin
            n_fail++;
            $display("MISMATCH at %0t: cycle limit %h reached, expected below %h", $time, cycles, 90000);
            report_and_stop();
        end
    end

    // Next reply byte is staged as soon as the current one is taken
    always @(negedge clock) begin
        if (frame_end === 1'b1) begin
            tx_idx = 0;
        end else if (tx_taken === 1'b1) begin
            tx_idx++;
        end
        tx_byte = pat(tx_idx);
    end

    task automatic frame(input logic [7:0] bytes[$]);
        logic [8:0] got;
        for (int i = 0; i < bytes.size(); i++) begin
            cmd_valid = 1'b1;
            cmd_byte = bytes[i];
            cmd_last = (i == bytes.size() - 1);
            while (cmd_ready !== 1'b1) @(negedge clock);
            @(negedge clock);
        end
        cmd_valid = 1'b0;
        repeat (2) @(negedge clock);
        while (host_active !== 1'b0) @(negedge clock);
        repeat (20) @(negedge clock);
        for (int i = 0; i < bytes.size(); i++) begin
            got = dev_q.pop_front();
            check(got, {i == 0, bytes[i]});
            got = {1'b0, host_q.pop_front()};
            if (i > 0) check(got, {1'b0, pat(i - 1)});
        end
    endtask

    task automatic write_status(input logic [7:0] value, input logic prot);
        int         rej;
        logic       ok;
        logic [7:0] want;
        rej = rejects;
        ok = !(status[spi_flash_pkg::LOCK_BIT] && !prot);
        want = ok ? (value & spi_flash_pkg::STATUS_WRITABLE_MASK) : status;
        protect_n = prot;
        @(negedge clock);
        frame('{spi_flash_pkg::WRITE_STATUS_OP, value});
        check({8'h00, status[spi_flash_pkg::BUSY_BIT]}, {8'h00, ok});
        check(9'(rejects - rej), {8'h00, !ok});
        repeat (80) @(negedge clock);
        check({1'b0, status}, {1'b0, want});
    endtask

    task automatic bang(input logic [7:0] value, input int nbits);
        for (int i = 7; i > 7 - nbits; i--) begin
            link_b.mosi = value[i];
            repeat (8) @(negedge clock);
            link_b.sck = 1'b1;
            repeat (8) @(negedge clock);
            link_b.sck = 1'b0;
        end
        link_b.mosi = ~link_b.mosi;
    endtask

    initial begin
        rst_n = 1'b0;
        {cmd_valid, cmd_last, mode3, pause} = 4'h0;
        protect_n = 1'b1;
        cmd_byte = 8'h00;
        {link_b.cs_n, link_b.sck, link_b.mosi, link_b.hold_n, link_b.wp_n} = 5'h03;
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        repeat (4) @(negedge clock);
        bang(8'h05, 8);
        repeat (20) @(negedge clock);
        check(9'(b_q.size()), 9'h000);
        link_b.cs_n = 1'b1;
        repeat (20) @(negedge clock);
        link_b.cs_n = 1'b0;
        repeat (20) @(negedge clock);
        bang(8'hA6, 4);
        link_b.hold_n = 1'b0;
        repeat (20) @(negedge clock);
        link_b.cs_n = 1'b1;
        repeat (20) @(negedge clock);
        link_b.cs_n = 1'b0;
        link_b.hold_n = 1'b1;
        repeat (20) @(negedge clock);
        bang(8'h3C, 8);
        link_b.cs_n = 1'b1;
        repeat (20) @(negedge clock);
        check({7'h00, 2'(b_q.size())}, 9'h001);
        check(b_q.pop_front(), {1'b1, 8'h3C});
        frame('{8'h03, 8'h12, 8'h34, 8'h56});
        mode3 = 1'b1;
        repeat (30) @(negedge clock);
        frame('{8'h0B, 8'hFE, 8'h01, 8'h80});
        write_status(8'hFF, 1'b1);
        write_status(8'h00, 1'b0);
        write_status(8'h00, 1'b1);
        write_status(8'h1C, 1'b0);
        mode3 = 1'b0;
        repeat (30) @(negedge clock);
        fork
            frame('{8'h02, 8'hA1, 8'hB2, 8'hC3, 8'hD4});
            begin
                repeat (700) @(negedge clock);
                pause = 1'b1;
                repeat (60) @(negedge clock);
                check({8'h00, link.miso_oe}, 9'h000);
                repeat (60) @(negedge clock);
                pause = 1'b0;
            end
        join
        for (int i = 0; i < spi_flash_pkg::PAGE_BYTES + 2; i++) fr.push_back(8'(i * 7));
        frame(fr);
        check({1'b0, last_off}, {1'b0, 8'(spi_flash_pkg::PAGE_BYTES + 1)});
        report_and_stop();
    end
endmodule
`default_nettype wire

// *** src/flash_frontend.sv ***
// Serial flash device end: select, bit shifting, pause and status write gating
// Summary of operation
// - Select high: deselected, serial output floats
// - Select low: accept instruction, return data
// - First instruction only after select falls
// - Status write completes after select rises
// - Serial output changes on clock fall
// - Serial input captured on clock rise
// - Clock may idle low or high
// - Serial input carries instruction, address, data
// - Protect pin low guards status register
// - Pause only while selected
// - Pause starts once clock is low
// - Pause ends once clock is low
// - Paused: output floats, inputs ignored
// - Paused: partial byte and frame kept
// - Select rise during pause resets interface
// - Pages of 256 bytes, 1M or 2M
// - Lock bit and low pin reject writes
`timescale 1ns/100ps
`default_nettype none
module flash_frontend (
    input  wire logic       CLOCK,
    input  wire logic       RST_N,
    spi_flash_if.device     LINK,
    output logic      [7:0] RX_BYTE,
    output logic            RX_VALID,
    output logic            RX_FIRST,
    output logic      [7:0] PAGE_OFFSET,
    input  wire logic [7:0] TX_BYTE,
    output logic            TX_TAKEN,
    output logic            FRAME_END,
    output logic      [7:0] STATUS,
    output logic            WRITE_REJECTED
);
    typedef struct packed {
        logic                                  cs_prev;
        logic                                  sck_prev;
        logic                                  selected;
        logic                                  hold;
        logic                                  first;
        logic [2:0]                            bit_cnt;
        logic [spi_flash_pkg::BYTE_BITS-1:0]   shift_in;
        logic [spi_flash_pkg::BYTE_BITS-1:0]   shift_out;
        logic [spi_flash_pkg::BYTE_BITS-1:0]   opcode;
        logic                                  got_data;
        logic [spi_flash_pkg::BYTE_BITS-1:0]   status_data;
        logic [spi_flash_pkg::BYTE_BITS-1:0]   pending;
        logic [spi_flash_pkg::BYTE_BITS-1:0]   status;
        logic [spi_flash_pkg::TIMER_BITS-1:0]  timer;
        logic [spi_flash_pkg::PAGE_BITS-1:0]   page_pos;
        logic                                  miso;
        logic                                  miso_oe;
        logic [spi_flash_pkg::BYTE_BITS-1:0]   rx_byte;
        logic                                  rx_valid;
        logic                                  rx_first;
        logic                                  tx_taken;
        logic                                  frame_end;
        logic                                  reject;
    } front_state_type;

    front_state_type state;
    front_state_type next_state;
    logic            cs_n;
    logic            sck;
    logic            mosi;
    logic            hold_n;
    logic            wp_n;
    logic            sck_rise;
    logic            sck_fall;
    logic [7:0]      captured;
    logic            byte_done;
    logic            reply_load;
    logic            status_write;
    logic            status_locked;

    // Select reads as low from reset, so a select held low at power-up is never an edge
    localparam logic [4:0] SYNC_RESET = 5'h0D;

    pin_sync #(
        .WIDTH       (5),
        .RESET_LEVEL (SYNC_RESET)
    ) u_sync (
        .CLOCK (CLOCK),
        .RST_N (RST_N),
        .PIN   ({LINK.cs_n,
                 LINK.hold_n,
                 LINK.wp_n,
                 LINK.sck,
                 LINK.mosi}),
        .LEVEL ({cs_n,
                 hold_n,
                 wp_n,
                 sck,
                 mosi})
    );

    assign sck_rise = sck & ~state.sck_prev;
    assign sck_fall = ~sck & state.sck_prev;
    assign captured = {state.shift_in[6:0], mosi};

    assign byte_done     = sck_rise && state.bit_cnt == spi_flash_pkg::LAST_BIT;
    // Reply bytes start only after the instruction byte has gone in
    assign reply_load    = sck_fall && state.bit_cnt == '0 && !state.first;
    assign status_write  = state.selected && state.got_data && state.opcode == spi_flash_pkg::WRITE_STATUS_OP;
    assign status_locked = state.status[spi_flash_pkg::LOCK_BIT] && !wp_n;

    always_comb begin
        next_state           = state;
        next_state.rx_valid  = 1'b0;
        next_state.tx_taken  = 1'b0;
        next_state.frame_end = 1'b0;
        next_state.reject    = 1'b0;
        next_state.cs_prev   = cs_n;
        next_state.sck_prev  = sck;
        // Internal write runs on its own timer, independent of the select line
        if (state.timer != '0) begin
            next_state.timer = state.timer - 1'b1;
            if (state.timer == 8'h01) begin
                next_state.status = state.pending;
            end
        end
        if (cs_n) begin
            // A write that meets a busy timer is dropped without a reject pulse
            if (status_write && state.timer == '0) begin
                if (status_locked) begin
                    next_state.reject = 1'b1;
                end else begin
                    next_state.pending = state.status_data & spi_flash_pkg::STATUS_WRITABLE_MASK;
                    next_state.timer   = spi_flash_pkg::STATUS_WRITE_CYCLES;
                end
            end
            next_state.frame_end = state.selected;
            // Any partial frame or pause is dropped here, including a pause in progress
            next_state.selected = 1'b0;
            next_state.hold     = 1'b0;
            next_state.bit_cnt  = '0;
            next_state.got_data = 1'b0;
        end else if (state.cs_prev && !cs_n) begin
            // The reset value of cs_prev is low, so a select held low from reset never starts a frame
            next_state.selected = 1'b1;
            next_state.first    = 1'b1;
            next_state.bit_cnt  = '0;
            next_state.page_pos = '0;
        end else if (state.selected) begin
            if (state.hold) begin
                if (hold_n && !sck) begin
                    next_state.hold = 1'b0;
                end
            end else begin
                if (sck_rise) begin
                    next_state.shift_in = captured;
                    next_state.bit_cnt  = state.bit_cnt + 1'b1;
                    if (byte_done) begin
                        next_state.rx_byte  = captured;
                        next_state.rx_valid = 1'b1;
                        next_state.rx_first = state.first;
                        next_state.first    = 1'b0;
                        if (state.first) begin
                            next_state.opcode = captured;
                        end else begin
                            next_state.page_pos = state.page_pos + 1'b1;
                            if (!state.got_data) begin
                                next_state.status_data = captured;
                                next_state.got_data    = 1'b1;
                            end
                        end
                    end
                end
                if (sck_fall) begin
                    if (reply_load) begin
                        next_state.miso      = TX_BYTE[7];
                        next_state.shift_out = {TX_BYTE[6:0], 1'b0};
                        next_state.tx_taken  = 1'b1;
                    end else begin
                        next_state.miso      = state.shift_out[7];
                        next_state.shift_out = {state.shift_out[6:0], 1'b0};
                    end
                end
                // Hold request taken with clock low, or on the edge that brought it low
                if (!hold_n && !sck) begin
                    next_state.hold = 1'b1;
                end
            end
        end
        // Enable follows the next state, so the pin is released in the cycle the frame ends or the pause starts
        next_state.miso_oe = next_state.selected && !next_state.hold;
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            state <= '{status: spi_flash_pkg::STATUS_RESET, pending: spi_flash_pkg::STATUS_RESET, default: '0};
        end else begin
            state <= next_state;
        end
    end

    assign LINK.miso_o  = state.miso;
    assign LINK.miso_oe = state.miso_oe;
    assign RX_BYTE      = state.rx_byte;
    assign RX_VALID     = state.rx_valid;
    assign RX_FIRST     = state.rx_first;
    assign PAGE_OFFSET  = state.page_pos;
    assign TX_TAKEN     = state.tx_taken;
    assign FRAME_END    = state.frame_end;
    assign WRITE_REJECTED = state.reject;
    assign STATUS       = {state.status[7:1], state.timer != '0};
endmodule
`default_nettype wire

// *** src/flash_master.sv ***
// SPI bus master end: makes the link clock, shifts bytes, requests pauses
`timescale 1ns/100ps
`default_nettype none
module flash_master (
    input  wire logic       CLOCK,
    input  wire logic       RST_N,
    spi_flash_if.host       LINK,
    input  wire logic       CMD_VALID,
    input  wire logic [7:0] CMD_BYTE,
    input  wire logic       CMD_LAST,
    output logic            CMD_READY,
    input  wire logic       MODE3,
    input  wire logic       PAUSE,
    input  wire logic       PROTECT_N,
    output logic      [7:0] RX_BYTE,
    output logic            RX_VALID,
    output logic            ACTIVE
);
    typedef enum logic [2:0] {IDLE, LEAD, LOW, HIGH, TRAIL} phase_type;

    typedef struct packed {
        phase_type                           phase;
        logic [spi_flash_pkg::HALF_BITS-1:0] cnt;
        logic [2:0]                          bit_cnt;
        logic [7:0]                          tx;
        logic [7:0]                          rx;
        logic                                last;
        logic                                mode3;
        logic                                cs_n;
        logic                                sck;
        logic                                mosi;
        logic                                hold_n;
        logic                                wp_n;
        logic [7:0]                          rx_byte;
        logic                                rx_valid;
    } master_state_type;

    localparam logic [spi_flash_pkg::HALF_BITS-1:0] HALF =
        spi_flash_pkg::HALF_BITS'(spi_flash_pkg::SCK_HALF_CYCLES);

    master_state_type state;
    master_state_type next_state;
    logic             miso;
    logic             load_ok;

    pin_sync #(
        .WIDTH       (1),
        .RESET_LEVEL (1'b0)
    ) u_sync (
        .CLOCK (CLOCK),
        .RST_N (RST_N),
        .PIN   (LINK.miso),
        .LEVEL (miso)
    );

    assign load_ok = state.cnt == '0 && ((state.phase == IDLE)
                     || (state.phase == HIGH && state.bit_cnt == spi_flash_pkg::LAST_BIT && !state.last));
    assign CMD_READY = load_ok;

    always_comb begin
        next_state          = state;
        next_state.rx_valid = 1'b0;
        next_state.wp_n     = PROTECT_N;
        if (state.cnt != '0) begin
            next_state.cnt = state.cnt - 1'b1;
        end
        unique case (state.phase)
            IDLE: begin
                next_state.sck   = MODE3;
                next_state.mode3 = MODE3;
                if (CMD_VALID && load_ok) begin
                    next_state.tx    = CMD_BYTE;
                    next_state.last  = CMD_LAST;
                    next_state.cs_n  = 1'b0;
                    next_state.cnt   = HALF;
                    next_state.phase = LEAD;
                end
            end
            LEAD: begin
                if (state.cnt == '0) begin
                    next_state.sck     = 1'b0;
                    next_state.mosi    = state.tx[7];
                    next_state.bit_cnt = '0;
                    next_state.cnt     = HALF;
                    next_state.phase   = LOW;
                end
            end
            LOW: begin
                // Pause only with select low and clock low; clock freezes meanwhile
                next_state.hold_n = !PAUSE;
                if (PAUSE) begin
                    next_state.cnt = HALF;
                end else if (state.cnt == '0 && state.hold_n) begin
                    next_state.sck   = 1'b1;
                    next_state.rx    = {state.rx[6:0], miso};
                    next_state.cnt   = HALF;
                    next_state.phase = HIGH;
                    // Byte is reported once here, so waiting high for the next byte cannot repeat it
                    if (state.bit_cnt == spi_flash_pkg::LAST_BIT) begin
                        next_state.rx_byte  = {state.rx[6:0], miso};
                        next_state.rx_valid = 1'b1;
                    end
                end
            end
            HIGH: begin
                if (state.cnt == '0) begin
                    if (state.bit_cnt == spi_flash_pkg::LAST_BIT) begin
                        if (state.last) begin
                            next_state.sck   = state.mode3;
                            next_state.cnt   = HALF;
                            next_state.phase = TRAIL;
                        end else if (CMD_VALID) begin
                            next_state.tx      = CMD_BYTE;
                            next_state.last    = CMD_LAST;
                            next_state.mosi    = CMD_BYTE[7];
                            next_state.sck     = 1'b0;
                            next_state.bit_cnt = '0;
                            next_state.cnt     = HALF;
                            next_state.phase   = LOW;
                        end
                    end else begin
                        next_state.tx      = {state.tx[6:0], 1'b0};
                        next_state.mosi    = state.tx[6];
                        next_state.sck     = 1'b0;
                        next_state.bit_cnt = state.bit_cnt + 1'b1;
                        next_state.cnt     = HALF;
                        next_state.phase   = LOW;
                    end
                end
            end
            TRAIL: begin
                if (state.cnt == '0) begin
                    next_state.cs_n  = 1'b1;
                    next_state.cnt   = HALF;
                    next_state.phase = IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            state <= '{phase: IDLE, cs_n: 1'b1, hold_n: 1'b1, wp_n: 1'b1, default: '0};
        end else begin
            state <= next_state;
        end
    end

    assign LINK.cs_n   = state.cs_n;
    assign LINK.sck    = state.sck;
    assign LINK.mosi   = state.mosi;
    assign LINK.hold_n = state.hold_n;
    assign LINK.wp_n   = state.wp_n;
    assign RX_BYTE     = state.rx_byte;
    assign RX_VALID    = state.rx_valid;
    assign ACTIVE      = !state.cs_n;
endmodule
`default_nettype wire

// *** src/pin_sync.sv ***
// Three-flop input synchroniser with agreement filter, one per bit
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
    parameter int               WIDTH       = 1,
    parameter logic [WIDTH-1:0] RESET_LEVEL = '0
) (
    input  wire logic             CLOCK,
    input  wire logic             RST_N,
    input  wire logic [WIDTH-1:0] PIN,
    output logic      [WIDTH-1:0] LEVEL
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] level;
    } sync_state_type;

    sync_state_type   state;
    sync_state_type   next_state;
    logic [WIDTH-1:0] agreed;

    // Only the second and third stages are compared; the first feeds the second alone
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        assign agreed[i] = (state.s2[i] == state.s3[i]) ? state.s3[i] : state.level[i];
    end

    always_comb begin
        next_state       = state;
        next_state.s1    = PIN;
        next_state.s2    = state.s1;
        next_state.s3    = state.s2;
        next_state.level = agreed;
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            state <= '{s1: RESET_LEVEL, s2: RESET_LEVEL, s3: RESET_LEVEL, level: RESET_LEVEL};
        end else begin
            state <= next_state;
        end
    end

    assign LEVEL = state.level;
endmodule
`default_nettype wire

// *** src/spi_flash_if.sv ***
// Pin bundle between the flash front end and its bus master
`timescale 1ns/100ps
`default_nettype none
interface spi_flash_if;
    logic cs_n;
    logic sck;
    logic mosi;
    logic miso_o;
    logic miso_oe;
    logic miso;
    logic hold_n;
    logic wp_n;

    // No pull on the returned data; a released pin reads as the inverse of its last bit
    assign miso = miso_oe ? miso_o : ~miso_o;

    modport device (
        input  cs_n,
        input  sck,
        input  mosi,
        input  hold_n,
        input  wp_n,
        output miso_o,
        output miso_oe
    );

    modport host (
        output cs_n,
        output sck,
        output mosi,
        output hold_n,
        output wp_n,
        input  miso
    );
endinterface
`default_nettype wire

// *** src/spi_flash_pkg.sv ***
// Shared constants for the serial flash front end and its bus master
package spi_flash_pkg;
    localparam int          CLOCK_PERIOD_NS      = 8;
    // Link clock half period made by the master; slow enough for both 3-flop input paths
    localparam int          SCK_HALF_NS          = 96;
    localparam int          SCK_HALF_CYCLES      = (SCK_HALF_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int          HALF_BITS            = 5;
    localparam int          BYTE_BITS            = 8;
    localparam logic [2:0]  LAST_BIT             = 3'h7;
    localparam int          PAGE_BYTES           = 256;
    localparam int          PAGE_BITS            = 8;
    localparam int          CAPACITY_SMALL       = 1048576;
    localparam int          CAPACITY_LARGE       = 2097152;
    localparam logic [7:0]  WRITE_STATUS_OP      = 8'h01;
    localparam int          LOCK_BIT             = 7;
    localparam int          BUSY_BIT             = 0;
    localparam logic [7:0]  STATUS_WRITABLE_MASK = 8'h9C;
    localparam logic [7:0]  STATUS_RESET         = 8'h00;
    localparam int          TIMER_BITS           = 8;
    localparam logic [7:0]  STATUS_WRITE_CYCLES  = 8'h40;
endpackage
